//--- common/indicator_defines.svh
// Offsets, field positions, reset values and timing counts of the indicator controller
`ifndef INDICATOR_DEFINES_SVH
`define INDICATOR_DEFINES_SVH
`define IND_OFFSET_CONTROL     4'h0
`define IND_OFFSET_PINCFG      4'h4
`define IND_OFFSET_STATUS      4'h8
`define IND_MODE_LSB           0
`define IND_MODE_MSB           1
`define IND_COLOUR_BIT         2
`define IND_FETCH_BIT          3
`define IND_CFG_INV_A_BIT      0
`define IND_CFG_INV_B_BIT      1
`define IND_CFG_OD_A_BIT       2
`define IND_CFG_OD_B_BIT       3
`define IND_CONTROL_RESET      4'h0
`define IND_PINCFG_RESET       4'hF
`define IND_CLK_HZ             25000000
`define IND_HALF_PERIOD_MS     500
`define IND_HALF_CYCLES        ((`IND_CLK_HZ / 1000) * `IND_HALF_PERIOD_MS)
`endif

//--- common/indicator_pkg.sv
// Types shared by the indicator controller
package indicator_pkg;
    typedef enum logic [1:0] {
        MODE_OFF   = 2'h0,
        MODE_BLINK = 2'h1,
        MODE_OFF2  = 2'h2,
        MODE_STEADY = 2'h3
    } ind_mode_t;

    typedef struct packed {
        logic      fetch;
        logic      colour;
        ind_mode_t mode;
    } ind_reg_t;

    typedef struct packed {
        logic softOffN;
        logic suspendN;
        logic powerGood;
    } sleep_in_t;

    typedef enum logic [2:0] {
        ST_SOFT_OFF    = 3'h0,
        ST_S3_NOPG     = 3'h1,
        ST_S3_PG       = 3'h3,
        ST_S0_NOPG     = 3'h2,
        ST_FULL_ON     = 3'h6
    } ind_state_t;
endpackage

//--- src/bicolor_status_indicator_ctrl.sv
// Two-pin bi-colour status indicator controller with Avalon-MM registers
//
// Summary of operation
// - After standby reset both pins are inverted, open-drain, active-low indicator outputs.
// - Each pin's polarity bit inverts or passes its own indicator output.
// - First pin active gives colour one, second gives colour two, both high off.
// - Blinking toggles at 1 Hz: 500 ms asserted, 500 ms deasserted.
// - Bits 1:0 select off, steady or blink; bits 3:2 select the colour.
// - Machine drives bits 2:0 in S3, S0 without power-good, and on transitions.
// - With soft-off input low, colour and mode clear; both indicators off.
// - S3 entry with power-good still high holds previous bits and outputs.
// - S3 without power-good blinks second pin; S0 without it blinks first.
// - Fully on with fetch bit clear loads colour 0, mode steady.
// - The code-fetch bit clears on main-rail reset.
// - Writable states: pins follow the four bits per the mode and colour.
// - Mismatched bits: blink uses bit 2, steady uses bit 3.
`timescale 1ns/1ns
`default_nettype none
`include "indicator_defines.svh"
module bicolor_status_indicator_ctrl
    import indicator_pkg::*;
#(
    parameter int unsigned HALF_CYCLES = `IND_HALF_CYCLES
)
(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        mainRailReset,
    input  wire logic        sleep_soft_off_n,
    input  wire logic        sleep_suspend_n,
    input  wire logic        supply_power_good,
    input  wire logic [3:0]  avsAddress,
    input  wire logic        avsRead,
    input  wire logic        avsWrite,
    input  wire logic [31:0] avsWriteData,
    input  wire logic [3:0]  avsByteEnable,
    output var  logic [31:0] avsReadData,
    output var  logic        avsWaitRequest,
    output var  logic [1:0]  avsResponse,
    input  wire logic        indicator_a_n_in,
    output var  logic        indicator_a_n_out,
    output var  logic        indicator_a_n_oe,
    input  wire logic        indicator_b_n_in,
    output var  logic        indicator_b_n_out,
    output var  logic        indicator_b_n_oe
);
    sleep_in_t  pins;
    ind_reg_t   ctrl_r;
    logic [3:0] pinCfg_r;
    ind_state_t state_r;
    ind_state_t state_nxt;
    logic       phase;
    logic       fetchRst;
    logic       accDone_r;
    logic       drvA;
    logic       drvB;
    logic       outA;
    logic       outB;

    pin_sync uSyncS5 (
        .clk_sys (clk_sys),
        .reset   (reset),
        .pinIn   (sleep_soft_off_n),
        .pinOut  (pins.softOffN)
    );

    pin_sync uSyncS3 (
        .clk_sys (clk_sys),
        .reset   (reset),
        .pinIn   (sleep_suspend_n),
        .pinOut  (pins.suspendN)
    );

    pin_sync uSyncPg (
        .clk_sys (clk_sys),
        .reset   (reset),
        .pinIn   (supply_power_good),
        .pinOut  (pins.powerGood)
    );

    blink_timer #(
        .HALF_CYCLES (HALF_CYCLES)
    ) uBlink (
        .clk_sys (clk_sys),
        .reset   (reset),
        .phase   (phase)
    );

    // Main-rail reset arrives asynchronously; it passes the same filter as the sleep pins
    pin_sync uSyncMain (
        .clk_sys (clk_sys),
        .reset   (reset),
        .pinIn   (mainRailReset),
        .pinOut  (fetchRst)
    );

    function automatic ind_state_t decodeState(input sleep_in_t s);
        if (!s.softOffN) begin
            decodeState = ST_SOFT_OFF;
        end else if (!s.suspendN) begin
            decodeState = s.powerGood ? ST_S3_PG : ST_S3_NOPG;
        end else begin
            decodeState = s.powerGood ? ST_FULL_ON : ST_S0_NOPG;
        end
    endfunction

    always_comb begin
        state_nxt = decodeState(pins);
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_r <= ST_FULL_ON;
        end else begin
            state_r <= state_nxt;
        end
    end

    function automatic logic isWrite(input logic [3:0] addr, input logic [3:0] off, input logic wr);
        isWrite = wr && (addr == off);
    endfunction

    // Control register: hardware-owned fields in sleep states, software-owned when fully on
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ctrl_r <= ind_reg_t'(`IND_CONTROL_RESET);
        end else begin
            case (state_nxt)
                ST_SOFT_OFF: begin
                    ctrl_r.colour <= 1'b0;
                    ctrl_r.mode   <= MODE_OFF;
                end
                ST_S3_NOPG: begin
                    ctrl_r.colour <= 1'b1;
                    ctrl_r.mode   <= MODE_BLINK;
                end
                ST_S0_NOPG: begin
                    ctrl_r.colour <= 1'b0;
                    ctrl_r.mode   <= MODE_BLINK;
                end
                ST_S3_PG: begin
                    ctrl_r.colour <= ctrl_r.colour;
                    ctrl_r.mode   <= ctrl_r.mode;
                end
                ST_FULL_ON: begin
                    if (state_r != ST_FULL_ON) begin
                        ctrl_r.colour <= ctrl_r.fetch;
                        ctrl_r.mode   <= MODE_STEADY;
                    end else if (isWrite(avsAddress, `IND_OFFSET_CONTROL, avsWrite && !accDone_r)
                                 && avsByteEnable[0]) begin
                        ctrl_r.colour <= avsWriteData[`IND_COLOUR_BIT];
                        ctrl_r.mode   <= ind_mode_t'(avsWriteData[`IND_MODE_MSB:`IND_MODE_LSB]);
                    end
                end
                default: begin
                    ctrl_r.colour <= ctrl_r.colour;
                    ctrl_r.mode   <= ctrl_r.mode;
                end
            endcase
            // Fetch bit: only standby reset, main-rail reset and software touch it; one process keeps one driver
            if (fetchRst) begin
                ctrl_r.fetch <= 1'b0;
            end else if (state_r == ST_FULL_ON && state_nxt == ST_FULL_ON
                         && isWrite(avsAddress, `IND_OFFSET_CONTROL, avsWrite && !accDone_r)
                         && avsByteEnable[0]) begin
                ctrl_r.fetch <= avsWriteData[`IND_FETCH_BIT];
            end
        end
    end

    // Pin configuration: polarity and open-drain, inverted open-drain on standby reset
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pinCfg_r <= `IND_PINCFG_RESET;
        end else if (isWrite(avsAddress, `IND_OFFSET_PINCFG, avsWrite && !accDone_r) && avsByteEnable[0]) begin
            pinCfg_r <= avsWriteData[3:0];
        end
    end

    // Active-high drive requests from mode, with colour in blink and fetch in steady
    always_comb begin
        drvA = 1'b0;
        drvB = 1'b0;
        case (ctrl_r.mode)
            MODE_BLINK: begin
                drvA = phase && !ctrl_r.colour;
                drvB = phase && ctrl_r.colour;
            end
            MODE_STEADY: begin
                drvA = !ctrl_r.fetch;
                drvB = ctrl_r.fetch;
            end
            default: begin
                drvA = 1'b0;
                drvB = 1'b0;
            end
        endcase
        outA = pinCfg_r[`IND_CFG_INV_A_BIT] ? !drvA : drvA;
        outB = pinCfg_r[`IND_CFG_INV_B_BIT] ? !drvB : drvB;
    end

    // Open-drain pins only pull low; push-pull drives both levels
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            indicator_a_n_out <= 1'b1;
            indicator_a_n_oe  <= 1'b0;
            indicator_b_n_out <= 1'b1;
            indicator_b_n_oe  <= 1'b0;
        end else begin
            indicator_a_n_out <= outA;
            indicator_a_n_oe  <= pinCfg_r[`IND_CFG_OD_A_BIT] ? !outA : 1'b1;
            indicator_b_n_out <= outB;
            indicator_b_n_oe  <= pinCfg_r[`IND_CFG_OD_B_BIT] ? !outB : 1'b1;
        end
    end

    // Bus slave: one wait cycle, answer on the second edge of the request
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            accDone_r <= 1'b0;
        end else begin
            accDone_r <= (avsRead || avsWrite) && !accDone_r;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            avsWaitRequest <= 1'b1;
        end else begin
            avsWaitRequest <= !((avsRead || avsWrite) && !accDone_r);
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            avsReadData <= 32'h0;
            avsResponse <= 2'h0;
        end else if (avsRead && !accDone_r) begin
            avsResponse <= 2'h0;
            case (avsAddress)
                `IND_OFFSET_CONTROL: avsReadData <= {28'h0, ctrl_r};
                `IND_OFFSET_PINCFG:  avsReadData <= {28'h0, pinCfg_r};
                `IND_OFFSET_STATUS:  avsReadData <= {24'h0, indicator_a_n_in, indicator_b_n_in, phase,
                                                     2'h0, pins.softOffN, pins.suspendN, pins.powerGood};
                default: begin
                    avsReadData <= 32'h0;
                    avsResponse <= 2'h2;
                end
            endcase
        end else if (avsWrite && !accDone_r) begin
            avsReadData <= 32'h0;
            avsResponse <= (avsAddress == `IND_OFFSET_CONTROL || avsAddress == `IND_OFFSET_PINCFG)
                           ? 2'h0 : 2'h2;
        end
    end
endmodule
`default_nettype wire

//--- src/blink_timer.sv
// Shared half-second phase generator for blinking indicators
`timescale 1ns/1ns
`default_nettype none
`include "indicator_defines.svh"
module blink_timer
    import indicator_pkg::*;
#(
    parameter int unsigned HALF_CYCLES = `IND_HALF_CYCLES
)
(
    input  wire logic clk_sys,
    input  wire logic reset,
    output var  logic phase
);
    logic [23:0] count_r;

    // One phase for both pins keeps the two colours in step
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            count_r <= 24'h0;
            phase   <= 1'b1;
        end else if (count_r == 24'(HALF_CYCLES - 1)) begin
            count_r <= 24'h0;
            phase   <= ~phase;
        end else begin
            count_r <= count_r + 24'h1;
        end
    end
endmodule
`default_nettype wire

//--- src/pin_sync.sv
// Three-flop synchroniser that accepts a change once the last two stages agree
`timescale 1ns/1ns
`default_nettype none
module pin_sync
    import indicator_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic pinIn,
    output var  logic pinOut
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // Cleared on reset: the sleep inputs then decode as soft-off until the pins have settled
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= pinIn;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pinOut <= 1'b0;
        end else if (s2_r == s3_r) begin
            pinOut <= s3_r;
        end
    end
endmodule
`default_nettype wire

//--- verification/indicator_monitor.sv
// Port-level checker for the bi-colour indicator controller
`timescale 1ns/1ns
`default_nettype none
`include "indicator_defines.svh"
module indicator_monitor
    import indicator_pkg::*;
#(
    parameter int unsigned HALF_CYCLES = 10
)
(
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        sleep_soft_off_n,
    input wire logic        sleep_suspend_n,
    input wire logic        supply_power_good,
    input wire logic [3:0]  avsAddress,
    input wire logic        avsRead,
    input wire logic        avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic        avsWaitRequest,
    input wire logic [1:0]  avsResponse,
    input wire logic        indicator_a_n_out,
    input wire logic        indicator_a_n_oe,
    input wire logic        indicator_b_n_out,
    input wire logic        indicator_b_n_oe
);
    logic [3:0]  cfg_r;
    logic [31:0] run_r;
    logic [31:0] gap_r;
    logic        bPrev_r;
    // Pins are open-drain with pull-ups, so a released pin reads high
    wire logic   aHi = !(indicator_a_n_oe && !indicator_a_n_out);
    wire logic   bHi = !(indicator_b_n_oe && !indicator_b_n_out);
    wire logic   req = avsRead || avsWrite;
    wire logic   s3 = sleep_soft_off_n && !sleep_suspend_n && !supply_power_good;
    wire logic   s0 = sleep_soft_off_n && sleep_suspend_n && !supply_power_good;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    // Shadow of the polarity bits: pin levels are only judged under inverted polarity
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cfg_r <= `IND_PINCFG_RESET;
        end else if (avsWrite && !avsWaitRequest && avsAddress == `IND_OFFSET_PINCFG) begin
            cfg_r <= avsWriteData[3:0];
        end
    end
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            run_r   <= 32'h0;
            gap_r   <= 32'h0;
            bPrev_r <= 1'b1;
        end else begin
            run_r   <= s3 ? run_r + 32'h1 : 32'h0;
            gap_r   <= (bHi != bPrev_r) ? 32'h1 : gap_r + 32'h1;
            bPrev_r <= bHi;
        end
    end
    sequence s_off8;
        !sleep_soft_off_n [*8];
    endsequence
    sequence s_s3_8;
        s3 [*8];
    endsequence
    sequence s_s0_8;
        s0 [*8];
    endsequence
    property p_answer;
        req && avsWaitRequest |=> !avsWaitRequest;
    endproperty
    property p_pulse;
        !avsWaitRequest |=> avsWaitRequest;
    endproperty
    property p_resp;
        req && !avsWaitRequest |-> avsResponse ==
            (((avsAddress inside {4'h0, 4'h4}) || (avsRead && avsAddress == 4'h8)) ? 2'h0 : 2'h2);
    endproperty
    property p_rstOff;
        $fell(reset) |-> aHi && bHi;
    endproperty
    property p_never;
        cfg_r == 4'hF |-> aHi || bHi;
    endproperty
    property p_off;
        s_off8 ##1 s_off8 |-> (aHi || !cfg_r[0]) && (bHi || !cfg_r[1]);
    endproperty
    property p_s3;
        s_s3_8 ##1 s_s3_8 |-> aHi || !cfg_r[0];
    endproperty
    property p_s0;
        s_s0_8 ##1 s_s0_8 |-> bHi || !cfg_r[1];
    endproperty
    property p_half;
        run_r > 3 * HALF_CYCLES + 16 && bHi != bPrev_r |-> gap_r == HALF_CYCLES;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer one cycle after request");
    a_pulse: assert property (p_pulse) else $error("waitrequest low too long");
    a_resp: assert property (p_resp) else $error("wrong response code");
    a_rstOff: assert property (p_rstOff) else $error("pin lit after reset");
    a_never: assert property (p_never) else $error("both pins low");
    a_off: assert property (p_off) else $error("pin lit in soft-off");
    a_s3: assert property (p_s3) else $error("first pin lit in S3");
    a_s0: assert property (p_s0) else $error("second pin lit in S0");
    a_half: assert property (p_half) else $error("blink half period wrong");
endmodule
bind bicolor_status_indicator_ctrl indicator_monitor #(.HALF_CYCLES(HALF_CYCLES)) i_indicator_monitor (
    .clk_sys(clk_sys), .reset(reset), .sleep_soft_off_n(sleep_soft_off_n), .sleep_suspend_n(sleep_suspend_n),
    .supply_power_good(supply_power_good), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWriteData(avsWriteData), .avsWaitRequest(avsWaitRequest), .avsResponse(avsResponse),
    .indicator_a_n_out(indicator_a_n_out), .indicator_a_n_oe(indicator_a_n_oe),
    .indicator_b_n_out(indicator_b_n_out), .indicator_b_n_oe(indicator_b_n_oe)
);
`default_nettype wire

//--- verification/indicator_partner.sv
// Model of the indicator lines and the sleep-state sources
`timescale 1ns/1ns
`default_nettype none
module indicator_partner
    import indicator_pkg::*;
(
    input  wire logic      aOut,
    input  wire logic      aOe,
    input  wire logic      bOut,
    input  wire logic      bOe,
    input  wire sleep_in_t sleepCmd,
    output var  logic      pinA,
    output var  logic      pinB,
    output var  logic      softOffN,
    output var  logic      suspendN,
    output var  logic      powerGood
);
    // Pull-ups: a released line reads high, never the last driven value
    assign pinA      = !(aOe && !aOut);
    assign pinB      = !(bOe && !bOut);
    assign softOffN  = sleepCmd.softOffN;
    assign suspendN  = sleepCmd.suspendN;
    assign powerGood = sleepCmd.powerGood;
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the bi-colour indicator controller
`timescale 1ns/1ns
`default_nettype none
module testbench
    import indicator_pkg::*;
;
    // Short blink half period keeps the run brief
    localparam int unsigned HC = 16;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic        mainRailReset = 1'b0;
    logic [3:0]  avsAddress = 4'h0;
    logic        avsRead = 1'b0;
    logic        avsWrite = 1'b0;
    logic [31:0] avsWriteData = 32'h0;
    logic [31:0] avsReadData;
    logic        avsWaitRequest;
    sleep_in_t   sleepCmd = 3'h0;
    logic        aOut, aOe, bOut, bOe, pinA, pinB, softOffN, suspendN, powerGood;
    logic [31:0] expQ[$];
    logic [31:0] mskQ[$];
    int          error_cnt = 0;
    int          tests_run = 0;
    int          seed = 32'h5395D79A;
    bicolor_status_indicator_ctrl #(.HALF_CYCLES(HC)) i_bicolor_status_indicator_ctrl (
        .clk_sys(clk_sys), .reset(reset), .mainRailReset(mainRailReset), .sleep_soft_off_n(softOffN),
        .sleep_suspend_n(suspendN), .supply_power_good(powerGood), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(4'hF), .avsReadData(avsReadData),
        .avsWaitRequest(avsWaitRequest), .avsResponse(), .indicator_a_n_in(pinA), .indicator_a_n_out(aOut),
        .indicator_a_n_oe(aOe), .indicator_b_n_in(pinB), .indicator_b_n_out(bOut), .indicator_b_n_oe(bOe));
    indicator_partner i_indicator_partner (.aOut(aOut), .aOe(aOe), .bOut(bOut), .bOe(bOe), .sleepCmd(sleepCmd),
        .pinA(pinA), .pinB(pinB), .softOffN(softOffN), .suspendN(suspendN), .powerGood(powerGood));
    always #20 clk_sys = ~clk_sys;
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic cmpRd(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
        tests_run++;
        if ((got & msk) !== (exp & msk)) begin
            error_cnt++;
            $display("mismatch t=%0t got %0h exp %0h", $time, got & msk, exp & msk);
        end
    endtask
    task automatic cmpCnt(input int got, input int exp);
        tests_run++;
        if (got != exp) begin
            error_cnt++;
            $display("mismatch t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        avsAddress <= adr;
        avsWriteData <= dat;
        avsWrite <= wr;
        avsRead <= !wr;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avsWaitRequest !== 1'b0 && n < 50);
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        if (n >= 50) begin
            error_cnt++;
            test_done();
        end
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [3:0] adr, input logic [31:0] exp, input logic [31:0] msk);
        expQ.push_back(exp);
        mskQ.push_back(msk);
        bus(1'b0, adr, 32'h0);
    endtask
    // Status: pins in bits 7:6, sleep inputs in bits 2:0; blink phase is masked
    task automatic st(input logic [1:0] p, input logic pm);
        rd(4'h8, {24'h0, p, 3'h0, sleepCmd}, pm ? 32'hC7 : 32'h07);
    endtask
    task automatic setSleep(input logic [2:0] v);
        sleepCmd <= sleep_in_t'(v);
        idle(24);
    endtask
    task automatic blink(input logic [2:0] s, input logic [3:0] ctl);
        int na;
        int nb;
        logic pa;
        logic pb;
        na = 0;
        nb = 0;
        setSleep(s);
        rd(4'h0, {28'h0, ctl}, 32'hF);
        pa = pinA;
        pb = pinB;
        repeat (6 * HC) begin
            @(posedge clk_sys);
            na += (pinA !== pa);
            nb += (pinB !== pb);
            pa = pinA;
            pb = pinB;
        end
        cmpCnt(na, ctl[2] ? 0 : 6);
        cmpCnt(nb, ctl[2] ? 6 : 0);
    endtask
    function automatic logic [1:0] pinsOf(input logic [3:0] v);
        if (v[1:0] != 2'h3) begin
            return 2'h3;
        end
        return v[3] ? 2'h2 : 2'h1;
    endfunction
    always @(posedge clk_sys) begin
        if (avsRead && avsWaitRequest === 1'b0 && expQ.size() > 0) begin
            cmpRd(avsReadData, expQ.pop_front(), mskQ.pop_front());
        end
    end
    initial begin
        logic [31:0] r;
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        idle(24);
        rd(4'h4, 32'hF, 32'hF);
        rd(4'h0, 32'h0, 32'hF);
        st(2'h3, 1'b1);
        bus(1'b1, 4'h0, 32'hF);
        rd(4'h0, 32'h0, 32'hF);
        blink(3'h6, 4'h1);
        blink(3'h4, 4'h5);
        setSleep(3'h7);
        rd(4'h0, 32'h3, 32'hF);
        st(2'h1, 1'b1);
        // Every register value, mismatched colour bits included
        for (int v = 0; v < 16; v++) begin
            r = $random(seed);
            bus(1'b1, 4'h0, {r[31:4], v[3:0]});
            idle(8);
            rd(4'h0, v, 32'hF);
            st(pinsOf(v[3:0]), v[1:0] != 2'h1);
        end
        setSleep(3'h5);
        rd(4'h0, 32'hF, 32'hF);
        st(2'h2, 1'b1);
        setSleep(3'h0);
        rd(4'h0, 32'h8, 32'hF);
        setSleep(3'h7);
        rd(4'h0, 32'hF, 32'hF);
        setSleep(3'h0);
        mainRailReset <= 1'b1;
        idle(4);
        mainRailReset <= 1'b0;
        idle(8);
        rd(4'h0, 32'h0, 32'hF);
        setSleep(3'h7);
        bus(1'b1, 4'h4, 32'hE);
        idle(8);
        st(2'h3, 1'b1);
        bus(1'b1, 4'h4, 32'hD);
        idle(8);
        st(2'h0, 1'b1);
        bus(1'b1, 4'h4, 32'hF);
        bus(1'b0, 4'hC, 32'h0);
        bus(1'b1, 4'hC, 32'hF);
        bus(1'b1, 4'h8, 32'hFF);
        rd(4'h0, 32'h3, 32'hF);
        bus(1'b1, 4'h0, 32'hC);
        idle(8);
        rd(4'h0, 32'hC, 32'hF);
        st(2'h3, 1'b1);
        test_done();
    end
endmodule
`default_nettype wire
